// [shared/dwnc_map.svh]
`ifndef DWNC_MAP_SVH
`define DWNC_MAP_SVH
// Notes on behaviour
// - Two independent wiper registers, ten bits each, 1024 positions.
// - Four-bit command field decodes sixteen distinct operations.
// - Scratchpad write loads host data straight into the addressed wiper.
// - Store copies a wiper to nonvolatile words; power-on reloads both wipers.
// - Restore command or preset strobe reloads wipers from nonvolatile words.
// - Write-protect asserted blocks every change of nonvolatile contents.
// - Increment and decrement move one step, one channel or both.
// - Shift left doubles, shift right halves the wiper setting.
// - Tolerance word held in nonvolatile storage, returned by a readback.
// - Twenty-six bytes of user nonvolatile storage, writable and readable.
// - Ready pulled low only during store, restore, read and preset work.
// - Store lasts typically 15 ms, at most 50 ms.
// - Nonvolatile reads for restore and readbacks finish within 30 us.
// - Ready falls no later than 0.3 ms after chip select rises.
// - Serial data captured on the rising serial clock edge.
// - Undefined extra output bit comes from the previous or current frame.
// - Preset pulse refreshes both wipers within about 30 us.
// - Power-on restore of both wipers takes about 30 us.
// - Data-out echoes input, or readback, delayed by one 24-bit frame.
// - Command executes only when chip select returns high.
// - Channel address zero is the first wiper, one the second.
// - Preset reload triggers on the rising edge of the preset input.

// ==================================================
// Clock and times
`define DWNC_CLK_KHZ      40000
`define DWNC_STORE_MS     15
`define DWNC_READ_US      7
`define DWNC_PRESET_US    30
`define DWNC_PWRUP_US     30
`define DWNC_STORE_CYC    (`DWNC_STORE_MS * `DWNC_CLK_KHZ)
`define DWNC_READ_CYC     ((`DWNC_READ_US * `DWNC_CLK_KHZ) / 1000)
`define DWNC_PRESET_CYC   ((`DWNC_PRESET_US * `DWNC_CLK_KHZ) / 1000)
`define DWNC_PWRUP_CYC    ((`DWNC_PWRUP_US * `DWNC_CLK_KHZ) / 1000)

// ==================================================
// Frame and storage layout
`define DWNC_FRAME_BITS   24
`define DWNC_WIPER_BITS   10
`define DWNC_WIPER_MID    10'h200
`define DWNC_WIPER_MAX    10'h3FF
`define DWNC_NV_WORDS     16
`define DWNC_NV_TOL_ADDR  4'hF
`define DWNC_USER_FIRST   4'h2
`define DWNC_USER_LAST    4'hE
`define DWNC_TOL_RESET    16'h0000
`endif

// [shared/dwnc_pkg.sv]
package dwnc_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_BUSY = 2'b10
	} dwnc_state_t;

	typedef enum logic [2:0] {
		ACT_NONE     = 3'b000,
		ACT_STORE    = 3'b001,
		ACT_RESTORE  = 3'b010,
		ACT_RD_NV    = 3'b011,
		ACT_RD_WIPER = 3'b100
	} dwnc_act_t;

	typedef enum logic [3:0] {
		OP_NOP         = 4'h0,
		OP_LOAD_ONE    = 4'h1,
		OP_STORE_WIPER = 4'h2,
		OP_STORE_DATA  = 4'h3,
		OP_SHR_ONE     = 4'h4,
		OP_SHR_BOTH    = 4'h5,
		OP_DEC_ONE     = 4'h6,
		OP_DEC_BOTH    = 4'h7,
		OP_LOAD_BOTH   = 4'h8,
		OP_READ_NV     = 4'h9,
		OP_READ_WIPER  = 4'hA,
		OP_WRITE       = 4'hB,
		OP_SHL_ONE     = 4'hC,
		OP_SHL_BOTH    = 4'hD,
		OP_INC_ONE     = 4'hE,
		OP_INC_BOTH    = 4'hF
	} dwnc_op_t;

	typedef struct packed {
		dwnc_op_t    op;
		logic [3:0]  addr;
		logic [15:0] data;
	} dwnc_cmd_t;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic sdi;
		logic preset_n;
		logic wp_n;
	} dwnc_pins_t;

endpackage

// [hdl/dwnc_ctrl.sv]
`timescale 1ns/10ps
`include "dwnc_map.svh"

module dwnc_ctrl
	import dwnc_pkg::*;
#(
	parameter int          STORE_CYC = `DWNC_STORE_CYC,
	parameter logic [15:0] TOL_WORD  = `DWNC_TOL_RESET
) (
	input  logic                 clk_sys,
	input  logic                 rst,
	input  logic                 ce,
	input  logic                 sclk,
	input  logic                 cs_n,
	input  logic                 sdi,
	input  logic                 preset_strobe_n,
	input  logic                 wp_n,
	output logic                 sdo,
	output logic                 sdo_oe_q,
	output logic                 rdy_out_q,
	output logic                 rdy_oe_q,
	output logic [1:0][9:0]      wiper_register_q
);

	// ==================================================
	// Constants
	localparam logic [19:0] STORE_LD  = 20'(STORE_CYC - 1);
	localparam logic [19:0] READ_LD   = 20'(`DWNC_READ_CYC - 1);
	localparam logic [19:0] PRESET_LD = 20'(`DWNC_PRESET_CYC - 1);
	localparam logic [19:0] PWRUP_LD  = 20'(`DWNC_PWRUP_CYC - 1);

	// ==================================================
	// Functions
	function automatic logic [9:0] wiper_op(input logic [9:0] w, input dwnc_op_t op, input logic [15:0] d);
		case (op)
			OP_WRITE:                wiper_op = d[9:0];
			OP_INC_ONE, OP_INC_BOTH: wiper_op = (w == `DWNC_WIPER_MAX) ? w : w + 10'h001;
			OP_DEC_ONE, OP_DEC_BOTH: wiper_op = (w == 10'h000) ? w : w - 10'h001;
			OP_SHL_ONE, OP_SHL_BOTH: wiper_op = w[9] ? `DWNC_WIPER_MAX : {w[8:0], 1'b0};
			OP_SHR_ONE, OP_SHR_BOTH: wiper_op = {1'b0, w[9:1]};
			default:                 wiper_op = w;
		endcase
	endfunction

	function automatic logic hits(input dwnc_op_t op, input logic ch, input logic sel);
		case (op)
			OP_INC_BOTH, OP_DEC_BOTH, OP_SHL_BOTH, OP_SHR_BOTH: hits = 1'b1;
			OP_WRITE, OP_INC_ONE, OP_DEC_ONE, OP_SHL_ONE, OP_SHR_ONE: hits = (ch == sel);
			default: hits = 1'b0;
		endcase
	endfunction

	// ==================================================
	// Pin synchronisers and edges
	dwnc_pins_t  pins_w;
	dwnc_pins_t  meta_q;
	dwnc_pins_t  sync_q;
	logic        sclk_prev_q;
	logic        cs_prev_q;
	logic        preset_prev_q;
	logic        sclk_rise_w;
	logic        cs_rise_w;
	logic        preset_rise_w;
	logic        frame_w;
	logic        wp_on_w;

	assign pins_w        = {sclk, cs_n, sdi, preset_strobe_n, wp_n};
	assign sclk_rise_w   = sync_q.sclk & ~sclk_prev_q;
	assign cs_rise_w     = sync_q.cs_n & ~cs_prev_q;
	assign preset_rise_w = sync_q.preset_n & ~preset_prev_q;
	assign frame_w       = ~sync_q.cs_n;
	assign wp_on_w       = ~sync_q.wp_n;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_q        <= '1;
			sync_q        <= '1;
			sclk_prev_q   <= 1'b1;
			cs_prev_q     <= 1'b1;
			preset_prev_q <= 1'b1;
		end else if (ce) begin
			meta_q        <= pins_w;
			sync_q        <= meta_q;
			sclk_prev_q   <= sync_q.sclk;
			cs_prev_q     <= sync_q.cs_n;
			preset_prev_q <= sync_q.preset_n;
		end
	end

	// ==================================================
	// Control state
	dwnc_state_t state_q;
	dwnc_state_t state_d;
	dwnc_act_t   act_q;
	dwnc_act_t   act_d;
	dwnc_act_t   read_act_w;
	logic [19:0] cnt_q;
	logic [19:0] cnt_d;
	dwnc_cmd_t   cmd_q;
	logic [23:0] shreg_q;
	logic        preset_pend_q;
	logic [15:0] nv_q [0:`DWNC_NV_WORDS-1];

	logic        exec_w;
	logic        done_w;
	logic        take_cmd_w;
	logic        preset_take_w;
	logic        sel_w;
	logic        store_ok_w;
	logic        exec_store_w;
	logic        exec_read_w;
	logic        restore_done_w;
	logic        rd_load_w;
	logic [23:0] rd_word_w;
	logic        nv_we_w;
	logic [3:0]  nv_addr_w;
	logic [15:0] nv_wdata_w;
	logic [9:0]  sel_wiper_w;
	logic [9:0]  nv_w0;
	logic [9:0]  nv_w1;
	logic [1:0][9:0] wiper_d;

	assign exec_w     = (state_q == ST_EXEC);
	assign done_w     = (state_q == ST_BUSY) && (cnt_q == 20'h0_0000);
	assign take_cmd_w = (state_q == ST_IDLE) && cs_rise_w;
	assign preset_take_w = (state_q == ST_IDLE) && preset_pend_q && sync_q.cs_n && !cs_rise_w;
	assign sel_w      = cmd_q.addr[0];
	assign sel_wiper_w = wiper_register_q[sel_w];
	assign nv_w0      = nv_q[0][9:0];
	assign nv_w1      = nv_q[1][9:0];

	// Stores are refused under write protection and at the tolerance word
	assign store_ok_w = !wp_on_w &&
		((cmd_q.op == OP_STORE_WIPER) ||
		 ((cmd_q.op == OP_STORE_DATA) && (cmd_q.addr != `DWNC_NV_TOL_ADDR)));
	assign exec_store_w = exec_w && store_ok_w;
	assign exec_read_w  = exec_w && ((cmd_q.op == OP_LOAD_BOTH) ||
		(cmd_q.op == OP_READ_NV) || (cmd_q.op == OP_READ_WIPER));
	assign read_act_w   = (cmd_q.op == OP_LOAD_BOTH) ? ACT_RESTORE :
		(cmd_q.op == OP_READ_NV) ? ACT_RD_NV : ACT_RD_WIPER;
	assign restore_done_w = done_w && (act_q == ACT_RESTORE);
	assign rd_load_w    = done_w && ((act_q == ACT_RD_NV) || (act_q == ACT_RD_WIPER));
	assign rd_word_w    = (act_q == ACT_RD_NV) ? {8'h00, nv_q[cmd_q.addr]} :
		{14'h0000, sel_wiper_w};

	assign nv_we_w    = done_w && (act_q == ACT_STORE);
	assign nv_addr_w  = (cmd_q.op == OP_STORE_WIPER) ? {3'h0, sel_w} : cmd_q.addr;
	assign nv_wdata_w = (cmd_q.op == OP_STORE_WIPER) ? {6'h00, sel_wiper_w} : cmd_q.data;

	// ==================================================
	// Wiper next values
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		assign wiper_d[ch] = restore_done_w ? nv_q[ch][9:0] :
			(exec_w && (cmd_q.op == OP_LOAD_ONE) && (sel_w == 1'(ch))) ? nv_q[ch][9:0] :
			(exec_w && hits(cmd_q.op, 1'(ch), sel_w)) ?
			wiper_op(wiper_register_q[ch], cmd_q.op, cmd_q.data) :
			wiper_register_q[ch];
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wiper_register_q <= {`DWNC_WIPER_MID, `DWNC_WIPER_MID};
		end else if (ce) begin
			wiper_register_q <= wiper_d;
		end
	end

	// ==================================================
	// Sequencer
	always_comb begin
		state_d = state_q;
		act_d   = act_q;
		cnt_d   = cnt_q;
		case (state_q)
			ST_IDLE: begin
				if (take_cmd_w) begin
					state_d = ST_EXEC;
				end else if (preset_take_w) begin
					state_d = ST_BUSY;
					act_d   = ACT_RESTORE;
					cnt_d   = PRESET_LD;
				end
			end
			ST_EXEC: begin
				state_d = ST_IDLE;
				act_d   = ACT_NONE;
				if (exec_store_w) begin
					state_d = ST_BUSY;
					act_d   = ACT_STORE;
					cnt_d   = STORE_LD;
				end else if (exec_read_w) begin
					state_d = ST_BUSY;
					act_d   = read_act_w;
					cnt_d   = READ_LD;
				end
			end
			ST_BUSY: begin
				if (cnt_q == 20'h0_0000) begin
					state_d = ST_IDLE;
					act_d   = ACT_NONE;
				end else begin
					cnt_d = cnt_q - 20'h0_0001;
				end
			end
			default: begin
				state_d = ST_IDLE;
				act_d   = ACT_NONE;
				cnt_d   = 20'h0_0000;
			end
		endcase
	end

	// Power-on starts straight into a restore of both wipers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q  <= ST_BUSY;
			act_q    <= ACT_RESTORE;
			cnt_q    <= PWRUP_LD;
			rdy_oe_q <= 1'b1;
		end else if (ce) begin
			state_q  <= state_d;
			act_q    <= act_d;
			cnt_q    <= cnt_d;
			rdy_oe_q <= (state_d == ST_BUSY);
		end
	end

	// Preset edge is held until the sequencer is free; a new edge beats the clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			preset_pend_q <= 1'b0;
		end else if (ce) begin
			preset_pend_q <= preset_rise_w | (preset_pend_q & ~preset_take_w);
		end
	end

	// ==================================================
	// Command capture and serial shift
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cmd_q <= dwnc_cmd_t'(24'h00_0000);
		end else if (ce && take_cmd_w) begin
			cmd_q <= dwnc_cmd_t'(shreg_q);
		end
	end

	// One register both receives and echoes, so the output trails by one frame
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			shreg_q <= 24'h00_0000;
		end else if (ce) begin
			if (rd_load_w) begin
				shreg_q <= rd_word_w;
			end else if (frame_w && sclk_rise_w) begin
				shreg_q <= {shreg_q[22:0], sync_q.sdi};
			end
		end
	end

	// Before the first edge the line shows the leftover top bit
	assign sdo = shreg_q[23];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sdo_oe_q  <= 1'b0;
			rdy_out_q <= 1'b0;
		end else if (ce) begin
			sdo_oe_q  <= frame_w;
			rdy_out_q <= 1'b0;
		end
	end

	// ==================================================
	// Nonvolatile words
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `DWNC_NV_WORDS; i++) begin
				nv_q[i] <= 16'h0000;
			end
			nv_q[0] <= {6'h00, `DWNC_WIPER_MID};
			nv_q[1] <= {6'h00, `DWNC_WIPER_MID};
			nv_q[`DWNC_NV_TOL_ADDR] <= TOL_WORD;
		end else if (ce && nv_we_w) begin
			nv_q[nv_addr_w] <= nv_wdata_w;
		end
	end

	// ==================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst || !ce);

	sequence s_busy_start;
		rdy_oe_q && (state_q == ST_BUSY);
	endsequence

	sequence s_cmd_taken;
		(state_q == ST_IDLE) && cs_rise_w;
	endsequence

	AST_EXEC_AFTER_CS:
		assert property ((state_q == ST_EXEC) |-> $past(take_cmd_w))
		else $error("Command executed without a chip select rise");

	AST_CS_TAKEN:
		assert property (s_cmd_taken |=> (state_q == ST_EXEC) && (cmd_q == $past(shreg_q)))
		else $error("Frame not taken on chip select rise");

	AST_STORE_START:
		assert property (exec_store_w |=> s_busy_start and (cnt_q == STORE_LD) and (act_q == ACT_STORE))
		else $error("Store did not start its timed busy period");

	AST_READ_TIME:
		assert property (exec_read_w |-> ##280 rdy_oe_q ##1 !rdy_oe_q)
		else $error("Read busy period has the wrong length");

	AST_RDY_QUICK:
		assert property (s_cmd_taken ##1 (exec_store_w || exec_read_w) |=> s_busy_start)
		else $error("Ready not lowered right after a flag command");

	AST_RDY_ONLY_BUSY:
		assert property ((state_q == ST_IDLE) && $past(state_q) == ST_EXEC
			&& !$past(exec_store_w) && !$past(exec_read_w) |-> !rdy_oe_q)
		else $error("Ready low after a command that does not drive it");

	AST_PRESET_START:
		assert property (preset_take_w |=> s_busy_start and (act_q == ACT_RESTORE) and (cnt_q == PRESET_LD))
		else $error("Preset edge did not start a restore");

	AST_RESTORE_LOAD:
		assert property (restore_done_w |=> (wiper_register_q[0] == $past(nv_w0))
			&& (wiper_register_q[1] == $past(nv_w1)) && !rdy_oe_q)
		else $error("Restore did not reload both wipers");

	AST_WRITE_DIRECT:
		assert property (exec_w && (cmd_q.op == OP_WRITE) |=> sel_wiper_w == $past(cmd_q.data[9:0]))
		else $error("Scratchpad write did not reach the wiper");

	AST_INC_STEP:
		assert property (exec_w && (cmd_q.op == OP_INC_ONE) && (sel_wiper_w != `DWNC_WIPER_MAX)
			|=> sel_wiper_w == $past(sel_wiper_w) + 10'h001)
		else $error("Increment did not move exactly one step");

	AST_SATURATE:
		assert property (exec_w && (cmd_q.op == OP_DEC_BOTH) && (wiper_register_q[0] == 10'h000)
			|=> wiper_register_q[0] == 10'h000)
		else $error("Decrement wrapped below zero");

	AST_SHIFT_HALF:
		assert property (exec_w && (cmd_q.op == OP_SHR_BOTH)
			|=> (wiper_register_q[0] == ($past(wiper_register_q[0]) >> 1))
			&& (wiper_register_q[1] == ($past(wiper_register_q[1]) >> 1)))
		else $error("Right shift did not halve both wipers");

	AST_WP_BLOCK:
		assert property (exec_w && wp_on_w |=> !((state_q == ST_BUSY) && (act_q == ACT_STORE)))
		else $error("Store started under write protection");

	AST_ECHO_SHIFT:
		assert property (frame_w && sclk_rise_w && !rd_load_w
			|=> (shreg_q[23:1] == $past(shreg_q[22:0])) && (shreg_q[0] == $past(sync_q.sdi)))
		else $error("Serial register did not shift on a clock rise");

endmodule

// [verif/dwnc_host_model.sv]
`timescale 1ns/10ps

module dwnc_host_model (
	input  wire logic        clk_sys,
	input  wire logic        sdo_line,
	output logic             sclk,
	output logic             cs_n,
	output logic             sdi,
	output logic [23:0]      rx_word,
	output logic             rx_stb
);

	initial begin
		sclk    = 1'b0;
		cs_n    = 1'b1;
		sdi     = 1'b1;
		rx_word = 24'h00_0000;
		rx_stb  = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// ==================================================
	// One 24-bit frame, MSB first, 200 ns serial clock
	task automatic xfer(input logic [23:0] tx);
		tick(32);                               // Idle gap before chip select falls
		cs_n = 1'b0;
		tick(4);
		for (int i = 23; i >= 0; i--) begin     // Whole frame of 24 bits
			sdi = tx[i];
			tick(4);
			rx_word[i] = sdo_line;
			sclk = 1'b1;
			tick(4);
			sclk = 1'b0;
		end
		tick(8);                                // Clock stopped before chip select rises
		sdi    = ~sdi;
		cs_n   = 1'b1;
		rx_stb = 1'b1;
		tick(1);
		rx_stb = 1'b0;
	endtask

endmodule

// [verif/dwnc_ctrl_tb.sv]
`timescale 1ns/10ps

module dwnc_ctrl_tb import dwnc_pkg::*;;

	localparam int          STORE_T = 40;
	localparam logic [15:0] TOL     = 16'hA5C3;

	logic              clk_sys, rst, ce, preset_strobe_n, wp_n;
	logic              sclk, cs_n, sdi, rx_stb, sdo, sdo_oe_q, rdy_out_q, rdy_oe_q;
	logic [23:0]       rx_word, rx_exp, echo_q;
	logic [1:0][9:0]   wiper_register_q;
	logic [9:0]        w [2];
	logic [15:0]       nv [16];
	logic [23:0]       exp_q [$];
	int                n_fail, tests_run, hi;
	wire               sdo_line;

	assign sdo_line = sdo_oe_q ? sdo : 1'b1;

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	dwnc_ctrl #(.STORE_CYC(STORE_T), .TOL_WORD(TOL)) i_dwnc_ctrl (
		.clk_sys(clk_sys), .rst(rst), .ce(ce), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
		.preset_strobe_n(preset_strobe_n), .wp_n(wp_n), .sdo(sdo), .sdo_oe_q(sdo_oe_q),
		.rdy_out_q(rdy_out_q), .rdy_oe_q(rdy_oe_q), .wiper_register_q(wiper_register_q));

	dwnc_host_model i_dwnc_host_model (
		.clk_sys(clk_sys), .sdo_line(sdo_line), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
		.rx_word(rx_word), .rx_stb(rx_stb));

	// ==================================================
	// Helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic near(input string what, input int n, input int e);
		check(what, 24'((n >= e - 1 && n <= e + 1) ? e : n), 24'(e));
	endtask

	task automatic busy_len(output int n);
		n = 0;
		for (int i = 0; i < 20 && rdy_oe_q !== 1'b1; i++) cyc(1);
		while (rdy_oe_q === 1'b1 && n < 3000) begin
			cyc(1);
			n++;
		end
	endtask

	function automatic logic [15:0] rv();
		return 16'($urandom_range(1023));
	endfunction

	function automatic logic [9:0] step(input logic [9:0] v, input logic [1:0] k);
		logic [10:0] t;
		case (k)
			2'd0: t = {1'b0, v} + 11'h001;
			2'd1: t = (v == 10'h000) ? 11'h000 : {1'b0, v} - 11'h001;
			2'd2: t = {v, 1'b0};
			default: t = {2'b00, v[9:1]};
		endcase
		return (t > 11'h3FF) ? 10'h3FF : t[9:0];
	endfunction

	task automatic wipers_ok();
		check("wipers", {4'h0, wiper_register_q}, {4'h0, w[1], w[0]});
	endtask

	// ==================================================
	// Command driver with reference model
	task automatic cmd(input dwnc_op_t op, input logic [3:0] a, input logic [15:0] d);
		dwnc_cmd_t c;
		logic      flg;
		int        e;
		c = '{op, a, d};
		flg = (op inside {OP_LOAD_BOTH, OP_READ_NV, OP_READ_WIPER}) ||
			(wp_n && (op == OP_STORE_WIPER || (op == OP_STORE_DATA && a != 4'hF)));
		e = (op inside {OP_STORE_WIPER, OP_STORE_DATA}) ? STORE_T : 280;
		exp_q.push_back(echo_q);
		echo_q = c;
		case (op)
			OP_NOP: ;
			OP_LOAD_ONE: w[a[0]] = nv[a[0]][9:0];
			OP_STORE_WIPER: if (wp_n) nv[a[0]] = {6'h00, w[a[0]]};
			OP_STORE_DATA: if (wp_n && a != 4'hF) nv[a] = d;
			OP_LOAD_BOTH: w = '{nv[0][9:0], nv[1][9:0]};
			OP_READ_NV: echo_q = {8'h00, nv[a]};
			OP_READ_WIPER: echo_q = {14'h0000, w[a[0]]};
			OP_WRITE: w[a[0]] = d[9:0];
			default: for (int ch = 0; ch < 2; ch++) if (op[0] || ch == a[0]) w[ch] = step(w[ch], {~op[1], ~op[3]});
		endcase
		i_dwnc_host_model.xfer(c);
		if (flg) begin
			busy_len(hi);
			near("busy_cycles", hi, e);
		end else begin
			cyc(12);
			check("ready_idle", 24'(rdy_oe_q), 24'h00_0000);
		end
		wipers_ok();
	endtask

	// ==================================================
	// Echo and readback monitor
	always @(posedge clk_sys) begin
		if (rx_stb === 1'b1) begin
			rx_exp = exp_q.pop_front();
			check("sdo_frame", rx_word, rx_exp);
		end
	end

	task automatic results();
		$display("Comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge clk_sys);
		n_fail++;
		results();
	end

	// ==================================================
	// Main sequence
	initial begin
		n_fail = 0;
		tests_run = 0;
		echo_q = 24'h00_0000;
		rst = 1'b1;
		ce = 1'b1;
		preset_strobe_n = 1'b1;
		wp_n = 1'b1;
		w = '{10'h200, 10'h200};
		for (int i = 0; i < 16; i++) nv[i] = (i < 2) ? 16'h0200 : 16'h0000;
		nv[15] = TOL;
		void'($urandom(75509));
		cyc(4);
		check("reset_out", {1'b0, wiper_register_q, sdo_oe_q, rdy_oe_q, rdy_out_q}, {1'b0, 20'h8_0200, 3'b010});
		rst = 1'b0;
		hi = 0;
		while (rdy_oe_q === 1'b1 && hi < 3000) begin
			cyc(1);
			hi++;
		end
		near("power_on_cycles", hi, 1200);
		wipers_ok();
		cmd(OP_WRITE, 4'h0, rv());
		cmd(OP_WRITE, 4'h1, rv());
		cmd(OP_READ_WIPER, 4'h0, 16'h0000);
		cmd(OP_READ_WIPER, 4'h1, 16'h0000);
		cmd(OP_NOP, 4'h0, 16'hFFFF);
		cmd(OP_WRITE, 4'h0, 16'h03FF);
		cmd(OP_WRITE, 4'h1, 16'h0000);
		cmd(OP_INC_ONE, 4'h0, 16'h0000);
		cmd(OP_DEC_ONE, 4'h1, 16'h0000);
		cmd(OP_INC_BOTH, 4'h0, 16'h0000);
		cmd(OP_DEC_BOTH, 4'h1, 16'h0000);
		cmd(OP_DEC_ONE, 4'h0, 16'h0000);
		cmd(OP_INC_ONE, 4'h1, 16'h0000);
		cmd(OP_WRITE, 4'h0, 16'h0000);
		cmd(OP_DEC_BOTH, 4'h0, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			cmd(OP_WRITE, 4'h0, rv());
			cmd(OP_WRITE, 4'h1, rv());
			cmd(OP_SHL_ONE, 4'h0, 16'h0000);
			cmd(OP_SHR_ONE, 4'h1, 16'h0000);
			cmd(OP_SHL_BOTH, 4'h0, 16'h0000);
			cmd(OP_SHR_BOTH, 4'h1, 16'h0000);
		end
		cmd(OP_STORE_WIPER, 4'h0, 16'h0000);
		cmd(OP_STORE_WIPER, 4'h1, 16'h0000);
		cmd(OP_WRITE, 4'h0, rv());
		cmd(OP_LOAD_ONE, 4'h0, 16'h0000);
		cmd(OP_WRITE, 4'h0, rv());
		cmd(OP_WRITE, 4'h1, rv());
		cmd(OP_LOAD_BOTH, 4'h0, 16'h0000);
		wp_n = 1'b0;
		cmd(OP_WRITE, 4'h1, rv());
		cmd(OP_STORE_WIPER, 4'h1, 16'h0000);
		cmd(OP_STORE_DATA, 4'h5, 16'h5A5A);
		wp_n = 1'b1;
		cmd(OP_LOAD_BOTH, 4'h0, 16'h0000);
		cmd(OP_READ_NV, 4'h5, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			hi = (i == 0) ? 2 : (i == 1) ? 14 : $urandom_range(13, 3);
			cmd(OP_STORE_DATA, 4'(hi), 16'($urandom));
			cmd(OP_READ_NV, 4'(hi), 16'h0000);
		end
		cmd(OP_STORE_DATA, 4'hF, 16'h1234);
		cmd(OP_READ_NV, 4'hF, 16'h0000);
		cmd(OP_NOP, 4'h0, 16'h0000);
		cmd(OP_WRITE, 4'h0, rv());
		cmd(OP_WRITE, 4'h1, rv());
		preset_strobe_n = 1'b0;
		cyc(8);
		check("preset_low_idle", 24'(rdy_oe_q), 24'h00_0000);
		preset_strobe_n = 1'b1;
		busy_len(hi);
		near("preset_cycles", hi, 1200);
		w = '{nv[0][9:0], nv[1][9:0]};
		wipers_ok();
		check("ready_value", 24'(rdy_out_q), 24'h00_0000);
		cmd(OP_NOP, 4'h0, 16'h0000);
		results();
	end

endmodule
